// ---- hdl/vcrt_addr_map.sv ----
`include "vcrt_params.svh"

module vcrt_addr_map
    import vcrt_pkg::*;
(
    input wire logic [15:0] ma,
    input wire logic [1:0] row_scan,
    input wire vcrt_amode_e amode,
    input wire logic wrap_off,
    input wire logic srs,
    input wire logic compat,
    output logic [15:0] fb
);

    logic [15:0] shaped;

    always_comb begin
        unique case (amode)
            amode_byte: begin
                shaped = ma;
            end
            amode_word: begin
                shaped = {ma[14:0], wrap_off ? ma[15] : ma[13]};
            end
            amode_dword: begin
                shaped = {ma[13:0], ma[13], ma[12]};
            end
            default: begin
                shaped = ma;
            end
        endcase
        fb = shaped;
        if (!srs) begin
            fb[14] = row_scan[1];
        end
        if (!compat) begin
            fb[13] = row_scan[0];
        end
    end

endmodule

// ---- hdl/vcrt_params.svh ----
`ifndef VCRT_PARAMS_SVH
`define VCRT_PARAMS_SVH

// -------------------------------------------------------------------------
// Ports and indexes
// -------------------------------------------------------------------------
`define VCRT_PORT_MONO 16'h03B5
`define VCRT_PORT_COLOR 16'h03D5
`define VCRT_IDX_VDE 8'h12
`define VCRT_IDX_OFS 8'h13
`define VCRT_IDX_ULM 8'h14
`define VCRT_IDX_VBS 8'h15
`define VCRT_IDX_VBE 8'h16
`define VCRT_IDX_MODE 8'h17

// -------------------------------------------------------------------------
// Field positions
// -------------------------------------------------------------------------
`define VCRT_B_DWORD 6
`define VCRT_B_CNT4 5
`define VCRT_UL_MSB 4
`define VCRT_B_CRES 7
`define VCRT_B_WORDBYTE 6
`define VCRT_B_WRAP 5
`define VCRT_B_CNT2 3
`define VCRT_B_HRS 2
`define VCRT_B_SRS 1
`define VCRT_B_COMPAT 0
`define VCRT_OVF_VDE9 6
`define VCRT_OVF_VDE8 1
`define VCRT_OVF_VBS8 3
`define VCRT_MSL_VBS9 5

// -------------------------------------------------------------------------
// Reset values and read masks
// -------------------------------------------------------------------------
`define VCRT_RST_REG 8'h00
`define VCRT_RMASK_ULM 8'h7F
`define VCRT_RMASK_MODE 8'hEF

`endif

// ---- hdl/vcrt_pkg.sv ----
`include "vcrt_params.svh"

package vcrt_pkg;

    typedef enum logic [1:0] {
        amode_byte,
        amode_word,
        amode_dword
    } vcrt_amode_e;

    typedef struct packed {
        logic [1:0] cnt;
    } vcrt_step_s;

    typedef struct packed {
        logic [7:0] r_vde;
        logic [7:0] r_ofs;
        logic [7:0] r_ulm;
        logic [7:0] r_vbs;
        logic [7:0] r_vbe;
        logic [7:0] r_mode;
        logic [7:0] rdata;
        logic rvalid;
        logic hdiv;
        logic [9:0] vline;
        logic vblank;
        logic vdisp;
        logic [15:0] ma;
        logic [15:0] row_base;
        logic [15:0] fb_addr;
        logic underline;
        logic hsync;
        logic vsync;
    } vcrt_top_s;

    // Addressing mode from DWord and word/byte bits
    function automatic vcrt_amode_e vcrt_amode(input logic dword, input logic wordbyte);
        if (dword) begin
            return amode_dword;
        end
        return wordbyte ? amode_byte : amode_word;
    endfunction

    // Data port hit for the selected mono/colour base
    function automatic logic vcrt_port_hit(input logic [15:0] addr, input logic color);
        return color ? (addr == `VCRT_PORT_COLOR) : (addr == `VCRT_PORT_MONO);
    endfunction

endpackage

// ---- hdl/vcrt_step_div.sv ----
`include "vcrt_params.svh"

module vcrt_step_div
    import vcrt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic clear,
    input wire logic count_en,
    input wire logic by4,
    input wire logic by2,
    output logic step
);

    vcrt_step_s st;
    vcrt_step_s next_st;
    logic [1:0] last;

    always_comb begin
        // Count-by-2 wins when both are set
        if (by2) begin
            last = 2'h1;
        end else if (by4) begin
            last = 2'h3;
        end else begin
            last = 2'h0;
        end
        step = ce && count_en && (st.cnt == last);
        next_st = st;
        if (ce) begin
            if (clear) begin
                next_st.cnt = 2'h0;
            end else if (count_en) begin
                next_st.cnt = (st.cnt == last) ? 2'h0 : st.cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// ---- hdl/vcrt_top.sv ----
`include "vcrt_params.svh"

module vcrt_top
    import vcrt_pkg::*;
#(
    parameter int MA_W = 16,
    parameter int VL_W = 10
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] crt_index,
    input wire logic color_io,
    output logic [7:0] io_rdata,
    output logic io_rvalid,
    input wire logic [7:0] timing_high_bits_reg,
    input wire logic [7:0] max_scan_line_reg,
    input wire logic [9:0] vert_total,
    input wire logic hretrace_pulse,
    input wire logic frame_start,
    input wire logic row_end,
    input wire logic [15:0] start_addr,
    input wire logic hdisp,
    input wire logic [4:0] row_scan,
    input wire logic text_mode,
    input wire logic native_mode,
    input wire logic hsync_in,
    input wire logic vsync_in,
    output logic hsync_out,
    output logic vsync_out,
    output logic [9:0] scan_line,
    output logic vdisp_active,
    output logic vblank,
    output logic underline,
    output logic [15:0] fb_addr
);

    // ---------------------------------------------------------------------
    // Parameter check
    // ---------------------------------------------------------------------
    if (MA_W != 16 || VL_W != 10) begin : g_bad_param
        $error("vcrt_top supports only 16-bit addresses and 10-bit lines");
    end

    vcrt_top_s st;
    vcrt_top_s next_st;
    logic step;
    logic [15:0] fb_comb;
    logic [9:0] vde;
    logic [9:0] vbs;
    logic [9:0] nline;
    logic vadv;
    logic wr_hit;
    logic rd_hit;
    logic [15:0] ofs_scaled;
    vcrt_amode_e amode;

    // ---------------------------------------------------------------------
    // Sub-blocks
    // ---------------------------------------------------------------------
    vcrt_step_div u_step (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .ce(ce),
        .clear(frame_start | row_end),
        .count_en(hdisp),
        .by4(st.r_ulm[`VCRT_B_CNT4]),
        .by2(st.r_mode[`VCRT_B_CNT2]),
        .step(step)
    );

    vcrt_addr_map u_map (
        .ma(st.ma),
        .row_scan(row_scan[1:0]),
        .amode(amode),
        .wrap_off(st.r_mode[`VCRT_B_WRAP]),
        .srs(st.r_mode[`VCRT_B_SRS]),
        .compat(st.r_mode[`VCRT_B_COMPAT]),
        .fb(fb_comb)
    );

    // ---------------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------------
    always_comb begin
        amode = vcrt_amode(st.r_ulm[`VCRT_B_DWORD], st.r_mode[`VCRT_B_WORDBYTE]);
        vde = {timing_high_bits_reg[`VCRT_OVF_VDE9], timing_high_bits_reg[`VCRT_OVF_VDE8],
               st.r_vde};
        vbs = {max_scan_line_reg[`VCRT_MSL_VBS9], timing_high_bits_reg[`VCRT_OVF_VBS8],
               st.r_vbs};
        // Offset counts words or DWords; counter steps in bytes of the mode
        ofs_scaled = (amode == amode_dword) ? {6'h00, st.r_ofs, 2'h0}
                                            : {7'h00, st.r_ofs, 1'h0};
        wr_hit = ce && io_wr && vcrt_port_hit(io_addr, color_io);
        rd_hit = ce && io_rd && vcrt_port_hit(io_addr, color_io);
        vadv = ce && hretrace_pulse && (!st.r_mode[`VCRT_B_HRS] || st.hdiv);
        nline = (st.vline == vert_total) ? 10'h000 : st.vline + 10'h001;
        next_st = st;
        if (ce) begin
            next_st.rvalid = 1'b0;
            if (wr_hit) begin
                unique case (crt_index)
                    `VCRT_IDX_VDE: next_st.r_vde = io_wdata;
                    `VCRT_IDX_OFS: next_st.r_ofs = io_wdata;
                    `VCRT_IDX_ULM: next_st.r_ulm = io_wdata & `VCRT_RMASK_ULM;
                    `VCRT_IDX_VBS: next_st.r_vbs = io_wdata;
                    `VCRT_IDX_VBE: next_st.r_vbe = io_wdata;
                    `VCRT_IDX_MODE: next_st.r_mode = io_wdata & `VCRT_RMASK_MODE;
                    default: next_st.r_vde = st.r_vde;
                endcase
            end
            if (rd_hit) begin
                next_st.rvalid = 1'b1;
                unique case (crt_index)
                    `VCRT_IDX_VDE: next_st.rdata = st.r_vde;
                    `VCRT_IDX_OFS: next_st.rdata = st.r_ofs;
                    `VCRT_IDX_ULM: next_st.rdata = st.r_ulm & `VCRT_RMASK_ULM;
                    `VCRT_IDX_VBS: next_st.rdata = st.r_vbs;
                    `VCRT_IDX_VBE: next_st.rdata = st.r_vbe;
                    `VCRT_IDX_MODE: next_st.rdata = st.r_mode & `VCRT_RMASK_MODE;
                    default: next_st.rvalid = 1'b0;
                endcase
            end
            // Divide-by-2 phase of the retrace clock
            if (hretrace_pulse) begin
                next_st.hdiv = st.r_mode[`VCRT_B_HRS] ? !st.hdiv : 1'b0;
            end
            if (vadv) begin
                next_st.vline = nline;
                if (nline == vbs) begin
                    next_st.vblank = 1'b1;
                end else if (nline[7:0] == st.r_vbe) begin
                    next_st.vblank = 1'b0;
                end
            end
            next_st.vdisp = (st.vline <= vde);
            if (frame_start) begin
                next_st.ma = start_addr;
                next_st.row_base = start_addr;
            end else if (row_end) begin
                next_st.row_base = st.row_base + ofs_scaled;
                next_st.ma = st.row_base + ofs_scaled;
            end else if (step) begin
                next_st.ma = st.ma + 16'h0001;
            end
            next_st.fb_addr = fb_comb;
            next_st.underline = text_mode
                && (row_scan == st.r_ulm[`VCRT_UL_MSB:0]);
            // Sync is forced inactive only in native modes with the CRES bit clear
            if (native_mode && !st.r_mode[`VCRT_B_CRES]) begin
                next_st.hsync = 1'b0;
                next_st.vsync = 1'b0;
            end else begin
                next_st.hsync = hsync_in;
                next_st.vsync = vsync_in;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------------
    assign io_rdata = st.rdata;
    assign io_rvalid = st.rvalid;
    assign hsync_out = st.hsync;
    assign vsync_out = st.vsync;
    assign scan_line = st.vline;
    assign vdisp_active = st.vdisp;
    assign vblank = st.vblank;
    assign underline = st.underline;
    assign fb_addr = st.fb_addr;

    // ---------------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    AST_DWORD_SHIFT: assert property (
        ce && st.r_ulm[`VCRT_B_DWORD] && st.r_mode[1:0] == 2'b11
        |=> fb_addr == {$past(st.ma[13:0]), $past(st.ma[13]), $past(st.ma[12])})
        else $error("DWord address shaping wrong");

    AST_WORD_WRAP: assert property (
        ce && amode == amode_word && !st.r_mode[`VCRT_B_WRAP]
        |=> fb_addr[0] == $past(st.ma[13]) && fb_addr[12:1] == $past(st.ma[11:0]))
        else $error("Word wrap bit 0 wrong");

    AST_ROWSCAN_B14: assert property (
        ce && !st.r_mode[`VCRT_B_SRS] |=> fb_addr[14] == $past(row_scan[1]))
        else $error("Bit 14 substitution missing");

    AST_ROWSCAN_B13: assert property (
        ce && !st.r_mode[`VCRT_B_COMPAT] |=> fb_addr[13] == $past(row_scan[0]))
        else $error("Bit 13 substitution missing");

    AST_STEP_BY4: assert property (
        step && st.r_ulm[`VCRT_B_CNT4] && !st.r_mode[`VCRT_B_CNT2] |=> !step [*3])
        else $error("Count-by-4 stepped early");

    AST_SYNC_FORCE: assert property (
        ce && native_mode && !st.r_mode[`VCRT_B_CRES] |=> !hsync_out && !vsync_out)
        else $error("Sync not forced inactive");

    AST_VBLANK_START: assert property (
        vadv && nline == vbs |=> vblank && scan_line == $past(nline))
        else $error("Blanking did not start");

    AST_VBLANK_END: assert property (
        vadv && nline != vbs && nline[7:0] == st.r_vbe |=> !vblank)
        else $error("Blanking did not end");

    AST_RESERVED_RD: assert property (
        rd_hit && crt_index == `VCRT_IDX_MODE |=> io_rvalid && !io_rdata[4])
        else $error("Reserved bit read nonzero");

    AST_UNDERLINE: assert property (
        ce && text_mode && row_scan == st.r_ulm[4:0] |=> underline)
        else $error("Underline not drawn");

    AST_ROW_ADVANCE: assert property (
        ce && row_end && !frame_start |=> st.ma == $past(st.row_base) + $past(ofs_scaled))
        else $error("Row base not advanced");

    AST_HALF_RATE: assert property (
        vadv && st.r_mode[`VCRT_B_HRS] |=> !st.hdiv)
        else $error("Half-rate phase wrong");

    AST_VDISP_END: assert property (
        ce |=> vdisp_active == ($past(st.vline) <= $past(vde)))
        else $error("Display end compare wrong");

    AST_OFS_WORD: assert property (
        ce && row_end && !frame_start && amode != amode_dword
        |=> st.row_base == $past(st.row_base) + 16'($past(st.r_ofs)) * 16'h0002)
        else $error("Word row offset wrong");

    AST_OFS_DWORD: assert property (
        ce && row_end && !frame_start && amode == amode_dword
        |=> st.row_base == $past(st.row_base) + 16'($past(st.r_ofs)) * 16'h0004)
        else $error("DWord row offset wrong");

    AST_WORD_SHIFT: assert property (
        ce && amode == amode_word
        |=> fb_addr[12:1] == $past(st.ma[11:0]) && fb_addr[15] == $past(st.ma[14]))
        else $error("Word address shaping wrong");

    AST_BYTE_PASS: assert property (
        ce && amode == amode_byte
        |=> fb_addr[12:0] == $past(st.ma[12:0]) && fb_addr[15] == $past(st.ma[15]))
        else $error("Byte address shaping wrong");

    AST_STEP_BY2: assert property (
        step && st.r_mode[`VCRT_B_CNT2] && !wr_hit |=> !step)
        else $error("Count-by-2 stepped early");

    AST_MA_STEP: assert property (
        step && !frame_start && !row_end |=> st.ma == $past(st.ma) + 16'h0001)
        else $error("Address counter did not step");

    AST_WRAP_OFF: assert property (
        ce && amode == amode_word && st.r_mode[`VCRT_B_WRAP]
        |=> fb_addr[0] == $past(st.ma[15]))
        else $error("Word address wrapped while disabled");

    AST_DWORD_LOW: assert property (
        ce && amode == amode_dword |=> fb_addr[1:0] == $past(st.ma[13:12]))
        else $error("DWord low address bits wrong");

    AST_KEEP_B14: assert property (
        ce && amode == amode_byte && st.r_mode[`VCRT_B_SRS]
        |=> fb_addr[14] == $past(st.ma[14]))
        else $error("Bit 14 replaced while disabled");

    AST_KEEP_B13: assert property (
        ce && amode == amode_byte && st.r_mode[`VCRT_B_COMPAT]
        |=> fb_addr[13] == $past(st.ma[13]))
        else $error("Bit 13 replaced while disabled");

    AST_RSV_ULM: assert property (
        rd_hit && crt_index == `VCRT_IDX_ULM |=> io_rvalid && !io_rdata[7])
        else $error("Reserved underline bit read nonzero");

    AST_RD_REFUSE: assert property (
        ce && io_rd && !vcrt_port_hit(io_addr, color_io) |=> !io_rvalid)
        else $error("Read answered on wrong port");

    AST_WR_OFS: assert property (
        wr_hit && crt_index == `VCRT_IDX_OFS |=> st.r_ofs == $past(io_wdata))
        else $error("Offset write lost");

    AST_SYNC_PASS: assert property (
        ce && !(native_mode && !st.r_mode[`VCRT_B_CRES])
        |=> hsync_out == $past(hsync_in) && vsync_out == $past(vsync_in))
        else $error("Sync not passed through");

    AST_FULL_RATE: assert property (
        ce && hretrace_pulse && !st.r_mode[`VCRT_B_HRS] |=> scan_line == $past(nline))
        else $error("Full-rate line advance missing");

    AST_UNDERLINE_OFF: assert property (
        ce && !(text_mode && row_scan == st.r_ulm[4:0]) |=> !underline)
        else $error("Underline drawn on wrong line");

    AST_VBLANK_HOLD: assert property (
        ce && !vadv |=> vblank == $past(vblank))
        else $error("Blanking changed off a line edge");

    COV_DWORD: cover property (step && amode == amode_dword);
    COV_BLANK: cover property (vadv && nline == vbs);
    COV_READ: cover property (io_rvalid);
    COV_SYNC_OFF: cover property (native_mode && !st.r_mode[`VCRT_B_CRES]);
    COV_ROW_WORD: cover property (row_end && amode != amode_dword);

endmodule

// ---- test/vcrt_sync_src.sv ----
// -------------------------------------------------------------------------
// Retrace and sync source beside the block
// -------------------------------------------------------------------------
module vcrt_sync_src (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic run,
    output logic hretrace_pulse,
    output logic hsync_in,
    output logic vsync_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] cnt;

    // Four clocks per line; outputs idle low and the count holds when stopped
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 2'h0;
            hretrace_pulse <= 1'b0;
            hsync_in <= 1'b0;
            vsync_in <= 1'b0;
        end else if (run) begin
            cnt <= cnt + 2'h1;
            hretrace_pulse <= (cnt == 2'h3);
            hsync_in <= (cnt < 2'h2);
            vsync_in <= cnt[1] ^ cnt[0];
        end else begin
            hretrace_pulse <= 1'b0;
            hsync_in <= 1'b0;
            vsync_in <= 1'b0;
        end
    end
endmodule

// ---- test/vcrt_top_tb.sv ----
`include "vcrt_params.svh"

module vcrt_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0, reset_n = 1'b0, io_wr = 1'b0, io_rd = 1'b0, color_io = 1'b1;
    logic [15:0] io_addr = 16'h0000, start_addr = 16'h0000;
    logic [7:0] io_wdata = 8'h00, crt_index = 8'h00, ovf = 8'h00, msl = 8'h00;
    logic frame_start = 1'b0, row_end = 1'b0, hdisp = 1'b0, text_mode = 1'b0;
    logic native_mode = 1'b0, run = 1'b0, ce = 1'b1;
    logic [4:0] row_scan = 5'h00;
    logic [7:0] io_rdata;
    logic io_rvalid, hsync_out, vsync_out, vdisp_active, vblank, underline;
    logic hretrace_pulse, hsync_in, vsync_in;
    logic [9:0] scan_line;
    logic [15:0] fb_addr;
    int errors = 0, checks_done = 0;

    always #2 ref_clk = ~ref_clk;

    vcrt_top DUT (.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .crt_index(crt_index),
        .color_io(color_io), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .timing_high_bits_reg(ovf), .max_scan_line_reg(msl), .vert_total(10'h190),
        .hretrace_pulse(hretrace_pulse), .frame_start(frame_start), .row_end(row_end),
        .start_addr(start_addr), .hdisp(hdisp), .row_scan(row_scan), .text_mode(text_mode),
        .native_mode(native_mode), .hsync_in(hsync_in), .vsync_in(vsync_in),
        .hsync_out(hsync_out), .vsync_out(vsync_out), .scan_line(scan_line),
        .vdisp_active(vdisp_active), .vblank(vblank), .underline(underline),
        .fb_addr(fb_addr));

    vcrt_sync_src partner (.ref_clk(ref_clk), .reset_n(reset_n), .run(run),
        .hretrace_pulse(hretrace_pulse), .hsync_in(hsync_in), .vsync_in(vsync_in));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
        io_addr = `VCRT_PORT_COLOR;
        crt_index = idx;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge ref_clk);
        io_wr = 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic reg_rd(input logic [7:0] idx, input logic [15:0] port, input logic ev,
            input logic [7:0] exp);
        io_addr = port;
        crt_index = idx;
        io_rd = 1'b1;
        @(negedge ref_clk);
        io_rd = 1'b0;
        check(16'(io_rvalid), 16'(ev));
        if (ev) check(16'(io_rdata), 16'(exp));
        @(negedge ref_clk);
    endtask

    // k: 0 DWord, 1 byte, 2 wrap off, 3 no bit-14 swap, 4 no bit-13 swap
    function automatic logic [15:0] exp_map(input logic [15:0] m, input logic [4:0] k,
            input logic [1:0] rs);
        logic [15:0] r;
        if (k[0]) r = {m[13:0], m[13], m[12]};
        else if (k[1]) r = m;
        else r = {m[14:0], k[2] ? m[15] : m[13]};
        if (!k[3]) r[14] = rs[1];
        if (!k[4]) r[13] = rs[0];
        return r;
    endfunction

    task automatic load(input logic [15:0] a);
        start_addr = a;
        frame_start = 1'b1;
        @(negedge ref_clk);
        frame_start = 1'b0;
    endtask

    task automatic t_regs;
        for (int i = 0; i < 6; i++) reg_rd(8'(8'h12 + i), `VCRT_PORT_COLOR, 1'b1, 8'h00);
        for (int i = 0; i < 6; i++) reg_wr(8'(8'h12 + i), 8'(8'hFF - i));
        for (int i = 0; i < 6; i++) begin
            reg_rd(8'(8'h12 + i), `VCRT_PORT_COLOR, 1'b1,
                8'(8'hFF - i) & (i == 2 ? 8'h7F : i == 5 ? 8'hEF : 8'hFF));
        end
        reg_rd(8'h18, `VCRT_PORT_COLOR, 1'b0, 8'h00);
        reg_rd(8'h13, `VCRT_PORT_MONO, 1'b0, 8'h00);
        color_io = 1'b0;
        reg_rd(8'h13, `VCRT_PORT_MONO, 1'b1, 8'hFE);
        color_io = 1'b1;
    endtask

    task automatic t_map;
        logic [4:0] k;
        logic [15:0] a;
        for (int i = 0; i < 32; i++) begin
            k = 5'(i);
            a = 16'h6B3C ^ 16'(i * 16'h0911);
            row_scan = k;
            reg_wr(8'h14, {1'b0, k[0], 6'h00});
            reg_wr(8'h17, {1'b1, k[1], k[2], 3'h0, k[3], k[4]});
            load(a);
            @(negedge ref_clk);
            check(fb_addr, exp_map(a, k, k[1:0]));
        end
    endtask

    task automatic t_step;
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            reg_wr(8'h14, {2'h0, c[1], 5'h00});
            reg_wr(8'h17, {4'hC, c[0], 3'h3});
            load(16'h0010);
            hdisp = 1'b1;
            repeat (8) @(negedge ref_clk);
            hdisp = 1'b0;
            repeat (2) @(negedge ref_clk);
            check(fb_addr, 16'h0010 + (c[0] ? 16'h0004 : c[1] ? 16'h0002 : 16'h0008));
        end
    endtask

    task automatic t_row;
        reg_wr(8'h13, 8'h05);
        for (int i = 0; i < 2; i++) begin
            reg_wr(8'h14, i ? 8'h40 : 8'h00);
            reg_wr(8'h17, 8'hC3);
            load(16'h0100);
            for (int r = 1; r < 3; r++) begin
                row_end = 1'b1;
                @(negedge ref_clk);
                row_end = 1'b0;
                @(negedge ref_clk);
                check(fb_addr, exp_map(16'(16'h0100 + r * (i ? 20 : 10)),
                    i ? 5'h1F : 5'h1E, 2'h0));
            end
        end
    endtask

    task automatic t_under;
        reg_wr(8'h14, 8'h0B);
        text_mode = 1'b1;
        for (int i = 0; i < 32; i++) begin
            row_scan = 5'(i);
            @(negedge ref_clk);
            check(16'(underline), 16'(i == 11));
        end
        text_mode = 1'b0;
        row_scan = 5'h0B;
        @(negedge ref_clk);
        check(16'(underline), 16'h0000);
    endtask

    task automatic t_hold;
        ce = 1'b0;
        reg_wr(8'h13, 8'h77);
        row_end = 1'b1;
        @(negedge ref_clk);
        row_end = 1'b0;
        @(negedge ref_clk);
        check(fb_addr, exp_map(16'h0128, 5'h1E, 2'h0));
        ce = 1'b1;
        reg_rd(8'h13, `VCRT_PORT_COLOR, 1'b1, 8'h05);
    endtask

    task automatic line_step;
        int n;
        n = 0;
        while (hretrace_pulse !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        check(16'(hretrace_pulse), 16'h0001);
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic t_vert;
        logic vb;
        logic [9:0] s0;
        vb = 1'b0;
        ovf = 8'h02;
        msl = 8'h20;
        reg_wr(8'h12, 8'h02);
        reg_wr(8'h15, 8'h04);
        reg_wr(8'h16, 8'h08);
        reg_wr(8'h17, 8'hC3);
        run = 1'b1;
        for (int l = 1; l <= 270; l++) begin
            line_step();
            if (l == 260) vb = 1'b1;
            else if (l % 256 == 8) vb = 1'b0;
            check(16'(scan_line), 16'(l));
            check(16'(vdisp_active), 16'(l <= 258));
            check(16'(vblank), 16'(vb));
            // Blank start bit 9 set over the first lines, then dropped
            if (l == 8) begin
                ovf = 8'h0A;
                msl = 8'h00;
            end
        end
        reg_wr(8'h17, 8'hC7);
        line_step();
        s0 = scan_line;
        repeat (4) line_step();
        check(16'(scan_line), 16'(s0 + 10'h002));
    endtask

    task automatic t_sync;
        logic ph, pv, en;
        for (int c = 0; c < 3; c++) begin
            native_mode = (c != 2);
            reg_wr(8'h17, {c == 0, 7'h43});
            en = (c == 0) || (c == 2);
            ph = hsync_in;
            pv = vsync_in;
            repeat (8) begin
                @(negedge ref_clk);
                check(16'(hsync_out), 16'(ph & en));
                check(16'(vsync_out), 16'(pv & en));
                ph = hsync_in;
                pv = vsync_in;
            end
        end
    endtask

    initial begin
        #80000;
        errors++;
        results();
    end

    initial begin
        repeat (6) @(negedge ref_clk);
        reset_n = 1'b1;
        @(negedge ref_clk);
        t_regs();
        t_map();
        t_step();
        t_row();
        t_under();
        t_hold();
        t_vert();
        t_sync();
        results();
    end
endmodule
